// ### dmx_defs.svh
// Constants of the data-move executor: opcodes, address map, reset values.
// Assumes inclusion by bare name from every file that decodes words.
`ifndef DMX_DEFS_SVH
`define DMX_DEFS_SVH

// Opcode fields, compared against the top bits of a program word, bits 11:8 for the pointer second word
`define DMX_OP_PTR_LOAD    6'h38   // Pointer load, first word, bits 15:10
`define DMX_OP_SECOND      4'hf    // Second word prefix, bits 15:12
`define DMX_OP_PTR_SECOND  4'h0    // Pointer load second word, bits 11:8
`define DMX_OP_COPY        6'h14   // Copy file, bits 15:10
`define DMX_OP_MOVE        4'hc    // File to file move, bits 15:12
`define DMX_OP_BANK        8'h01   // Bank select load, bits 15:8
`define DMX_OP_LIT         8'h0e   // Literal to accumulator, bits 15:8
`define DMX_OP_STORE       7'h37   // Accumulator store, bits 15:9

// Field positions inside a word
`define DMX_BIT_DEST       9       // Destination select bit
`define DMX_BIT_BANK       8       // Bank access bit

// Pointer index range
`define DMX_PTR_LAST       2'd2    // Highest valid pointer index

// Data space map
`define DMX_ACCESS_SPLIT   8'h80   // Access bank low/high split offset
`define DMX_ACCESS_LOW     4'h0    // Access bank lower half page
`define DMX_ACCESS_HIGH    4'hf    // Access bank upper half page
`define DMX_ACC_ADDR       12'hfe8 // Accumulator location in data space

// Reset values
`define DMX_RST_BYTE       8'h00
`define DMX_RST_WORD       16'h0000
`define DMX_RST_PTR        16'h0000
`define DMX_ZERO_NIBBLE    4'h0

`endif

// ### dmx_pkg.sv
// Types of the data-move executor: quarter phases, operation kinds, sequence.
// Assumes nothing of its surroundings.
package dmx_pkg;

  // Quarter phase of one instruction cycle
  typedef enum logic [3:0] {
    dmx_ph_q1 = 4'b0001,
    dmx_ph_q2 = 4'b0010,
    dmx_ph_q3 = 4'b0100,
    dmx_ph_q4 = 4'b1000
  } dmx_phase_t;

  // Operation executed in the current instruction cycle
  typedef enum logic [8:0] {
    dmx_k_nop      = 9'h001,
    dmx_k_ptr_hi   = 9'h002,
    dmx_k_ptr_lo   = 9'h004,
    dmx_k_copy     = 9'h008,
    dmx_k_move_src = 9'h010,
    dmx_k_move_dst = 9'h020,
    dmx_k_bank     = 9'h040,
    dmx_k_lit      = 9'h080,
    dmx_k_store    = 9'h100
  } dmx_kind_t;

  // Expectation for the next fetched word
  typedef enum logic [2:0] {
    dmx_seq_idle  = 3'b001,
    dmx_seq_ptr2  = 3'b010,
    dmx_seq_move2 = 3'b100
  } dmx_seq_t;

endpackage : dmx_pkg

// ### dmx_quarter_phase.sv
// Quarter phase sequencer: four clocks make one instruction cycle.
// Assumes one free running clock and an asynchronous high reset.
module dmx_quarter_phase
  import dmx_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_reset,
  output dmx_phase_t o_phase
);

  dmx_phase_t next_phase; // Following quarter

  // Step Q1 to Q4 and wrap
  always_comb begin
    case (o_phase)
      dmx_ph_q1: next_phase = dmx_ph_q2;
      dmx_ph_q2: next_phase = dmx_ph_q3;
      dmx_ph_q3: next_phase = dmx_ph_q4;
      dmx_ph_q4: next_phase = dmx_ph_q1;
      default:   next_phase = dmx_ph_q1;
    endcase
  end

  // Phase register, Q1 out of reset
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_phase <= dmx_ph_q1;
    end else begin
      o_phase <= next_phase;
    end
  end

endmodule : dmx_quarter_phase

// ### dmx_exec.sv
// Data-move instruction executor: decodes words and moves bytes.
// Assumes a data memory that answers a read one clock after o_rd_en,
// and a fetch unit that offers a word with i_word_valid during Q1.
`include "dmx_defs.svh"
module dmx_exec
  import dmx_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic [15:0] i_word,
  input  wire logic        i_word_valid,
  input  wire logic [7:0]  i_rd_data,
  output dmx_phase_t       o_phase,
  output logic             o_rd_en,
  output logic [11:0]      o_rd_addr,
  output logic             o_wr_en,
  output logic [11:0]      o_wr_addr,
  output logic [7:0]       o_wr_data,
  output logic [7:0]       o_accum,
  output logic [7:0]       o_bank,
  output logic [15:0]      o_ptr0,
  output logic [15:0]      o_ptr1,
  output logic [15:0]      o_ptr2,
  output logic             o_flag_n,
  output logic             o_flag_z
);

  // Data space address of a banked file operand
  function automatic logic [11:0] dmx_file_addr(
    input logic [7:0] f,
    input logic       a,
    input logic [3:0] bank
  );
    logic [3:0] page;
    page = (f < `DMX_ACCESS_SPLIT) ? `DMX_ACCESS_LOW : `DMX_ACCESS_HIGH;
    dmx_file_addr = a ? {bank, f} : {page, f};
  endfunction : dmx_file_addr

  // True where an address names the accumulator
  function automatic logic dmx_is_acc(input logic [11:0] addr);
    dmx_is_acc = (addr == `DMX_ACC_ADDR);
  endfunction : dmx_is_acc

  logic [15:0] ir;          // Word of the current cycle
  dmx_kind_t   kind;        // Operation of the current cycle
  dmx_seq_t    seq;         // Word expected next
  logic [1:0]  ptr_sel;     // Pointer chosen by the first word
  logic        src_acc;     // Read source is the accumulator
  logic [7:0]  hold_val;    // Value read in Q3, kept for the move
  logic [15:0] ptr [3];     // Pointers, {high byte, low byte}

  dmx_kind_t   next_kind;   // Kind decoded from the offered word
  dmx_seq_t    next_seq;    // Sequence after this word

  // Quarter phases
  dmx_quarter_phase u_phase (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .o_phase (o_phase)
  );

  wire ph_q1 = (o_phase == dmx_ph_q1);
  wire ph_q3 = (o_phase == dmx_ph_q3);
  wire ph_q4 = (o_phase == dmx_ph_q4);

  // Opcode matches on the offered word
  wire w_ptr    = (i_word[15:10] == `DMX_OP_PTR_LOAD);
  wire w_second = (i_word[15:12] == `DMX_OP_SECOND);
  wire w_ptr_lo = w_second &&
                  (i_word[11:8] == `DMX_OP_PTR_SECOND);
  wire w_copy   = (i_word[15:10] == `DMX_OP_COPY);
  wire w_move   = (i_word[15:12] == `DMX_OP_MOVE);
  wire w_bank   = (i_word[15:8] == `DMX_OP_BANK);
  wire w_lit    = (i_word[15:8] == `DMX_OP_LIT);
  wire w_store  = (i_word[15:9] == `DMX_OP_STORE);

  // Second words finish their pair; a lone prefixed word is a no-op
  assign next_kind =
    (seq == dmx_seq_ptr2)  ? (w_ptr_lo ? dmx_k_ptr_lo : dmx_k_nop) :
    (seq == dmx_seq_move2) ? (w_second ? dmx_k_move_dst : dmx_k_nop) :
    w_ptr   ? dmx_k_ptr_hi   :
    w_copy  ? dmx_k_copy     :
    w_move  ? dmx_k_move_src :
    w_bank  ? dmx_k_bank     :
    w_lit   ? dmx_k_lit      :
    w_store ? dmx_k_store    :
    dmx_k_nop;

  assign next_seq = (seq != dmx_seq_idle) ? dmx_seq_idle :
                    w_ptr  ? dmx_seq_ptr2  :
                    w_move ? dmx_seq_move2 :
                    dmx_seq_idle;

  // Read address for the coming Q2
  wire [11:0] next_rd_addr = w_move ? i_word[11:0] :
    dmx_file_addr(i_word[7:0], i_word[`DMX_BIT_BANK], o_bank[3:0]);
  wire next_reads = (next_kind == dmx_k_copy) ||
                    (next_kind == dmx_k_move_src);
  wire next_src_acc = dmx_is_acc(next_rd_addr);

  // Word capture at the end of Q1
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ir      <= `DMX_RST_WORD;
      kind    <= dmx_k_nop;
      seq     <= dmx_seq_idle;
      ptr_sel <= 2'h0;
      src_acc <= 1'b0;
    end else if (ph_q1) begin
      ir      <= i_word;
      kind    <= i_word_valid ? next_kind : dmx_k_nop;
      seq     <= i_word_valid ? next_seq : seq;
      ptr_sel <= (i_word_valid && next_kind == dmx_k_ptr_hi) ?
                 i_word[9:8] : ptr_sel;
      src_acc <= next_src_acc;
    end
  end

  // Data read strobe stands through Q2 only; never in the move's 2nd cycle
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_rd_en   <= 1'b0;
      o_rd_addr <= 12'h000;
    end else begin
      o_rd_en   <= ph_q1 && i_word_valid && next_reads &&
                   !next_src_acc;
      o_rd_addr <= ph_q1 ? next_rd_addr : o_rd_addr;
    end
  end

  // Operand value seen in Q3
  wire [7:0]  read_val  = src_acc ? o_accum : i_rd_data;
  wire [11:0] file_addr = dmx_file_addr(ir[7:0], ir[`DMX_BIT_BANK],
                                        o_bank[3:0]);
  wire        file_acc  = dmx_is_acc(file_addr);
  wire        dst_acc   = dmx_is_acc(ir[11:0]);
  wire        to_file   = ir[`DMX_BIT_DEST];

  // Keep the read value for Q4 and the move's second cycle
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      hold_val <= `DMX_RST_BYTE;
    end else if (ph_q3 && (kind == dmx_k_copy ||
                           kind == dmx_k_move_src)) begin
      hold_val <= read_val;
    end
  end

  // Data space writes, driven through Q4
  wire wr_copy  = (kind == dmx_k_copy) && to_file && !file_acc;
  wire wr_store = (kind == dmx_k_store) && !file_acc;
  wire wr_move  = (kind == dmx_k_move_dst) && !dst_acc;
  wire [11:0] next_wr_addr = wr_move ? ir[11:0] : file_addr;
  wire [7:0]  next_wr_data = wr_copy ? read_val :
                             wr_store ? o_accum : hold_val;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_wr_en   <= 1'b0;
      o_wr_addr <= 12'h000;
      o_wr_data <= `DMX_RST_BYTE;
    end else begin
      o_wr_en   <= ph_q3 && (wr_copy || wr_store || wr_move);
      o_wr_addr <= ph_q3 ? next_wr_addr : o_wr_addr;
      o_wr_data <= ph_q3 ? next_wr_data : o_wr_data;
    end
  end

  // Accumulator next value at the end of Q4
  wire [7:0] next_accum =
    (kind == dmx_k_lit) ? ir[7:0] :
    (kind == dmx_k_copy && (!to_file || file_acc)) ? hold_val :
    (kind == dmx_k_move_dst && dst_acc) ? hold_val :
    o_accum;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_accum <= `DMX_RST_BYTE;
    end else if (ph_q4) begin
      o_accum <= next_accum;
    end
  end

  // Negative and zero flags, changed by the copy only
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_flag_n <= 1'b0;
      o_flag_z <= 1'b0;
    end else if (ph_q4 && kind == dmx_k_copy) begin
      o_flag_n <= hold_val[7];
      o_flag_z <= (hold_val == `DMX_RST_BYTE);
    end
  end

  // Bank select, upper nibble held at zero
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_bank <= `DMX_RST_BYTE;
    end else if (ph_q4 && kind == dmx_k_bank) begin
      o_bank <= {`DMX_ZERO_NIBBLE, ir[3:0]};
    end
  end

  // Pointers; an index of 3 leaves every pointer unchanged
  wire ptr_ok = (ptr_sel <= `DMX_PTR_LAST);
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      for (int i = 0; i < 3; i++) begin
        ptr[i] <= `DMX_RST_PTR;
      end
    end else if (ph_q4 && ptr_ok && kind == dmx_k_ptr_hi) begin
      ptr[ptr_sel][15:8] <= {`DMX_ZERO_NIBBLE, ir[3:0]};
    end else if (ph_q4 && ptr_ok && kind == dmx_k_ptr_lo) begin
      ptr[ptr_sel][7:0] <= ir[7:0];
    end
  end

  assign o_ptr0 = ptr[0];
  assign o_ptr1 = ptr[1];
  assign o_ptr2 = ptr[2];

  // Checks
  default clocking dmx_cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  a_bank_upper_zero: assert property (o_bank[7:4] == 4'h0)
    else $error("bank select upper nibble not zero");
  a_lit_to_acc: assert property ((ph_q4 && kind == dmx_k_lit) |=>
      o_accum == $past(ir[7:0]) && $stable(o_flag_n) && $stable(o_flag_z))
    else $error("literal not loaded or flags changed");
  a_ptr_high_load: assert property ((ph_q4 && kind == dmx_k_ptr_hi
      && ptr_sel == 2'd2) |=> ptr[2][15:8] == {4'h0, $past(ir[3:0])})
    else $error("pointer high byte not loaded");
  a_ptr_pair_order: assert property ((ph_q4 && kind == dmx_k_ptr_hi)
      |=> ##1 ((kind == dmx_k_ptr_lo) || (kind == dmx_k_nop)))
    else $error("pointer second word not paired");
  a_copy_zero_flag: assert property ((ph_q4 && kind == dmx_k_copy)
      |=> o_flag_z == ($past(hold_val) == 8'h00)
          && o_flag_n == $past(hold_val[7]))
    else $error("copy flags wrong");
  a_move_src_read: assert property ((ph_q1 && i_word_valid
      && next_kind == dmx_k_move_src && !next_src_acc)
      |=> o_rd_en && o_rd_addr == $past(i_word[11:0]) ##1 !o_rd_en)
    else $error("move source read not in Q2");
  a_move_no_read: assert property ((kind == dmx_k_move_dst)
      |-> !o_rd_en)
    else $error("dummy read in move second cycle");
  a_move_dst_write: assert property ((ph_q3 && wr_move)
      |=> o_wr_en && o_wr_addr == $past(ir[11:0])
          && o_wr_data == $past(hold_val) && ph_q4)
    else $error("move destination write wrong");
  a_store_write: assert property ((ph_q3 && wr_store)
      |=> o_wr_en && o_wr_data == o_accum && $stable(o_flag_z))
    else $error("store write wrong");
  a_banked_read: assert property ((o_rd_en && $past(w_copy)
      && $past(i_word[8])) |-> o_rd_addr[11:8] == o_bank[3:0])
    else $error("banked address wrong");
  a_lone_second: assert property ((ph_q1 && i_word_valid && w_second
      && seq == dmx_seq_idle) |=> kind == dmx_k_nop)
    else $error("second word executed alone");

  c_ptr_load: cover property (ph_q4 && kind == dmx_k_ptr_lo);
  c_move_acc: cover property (ph_q4 && kind == dmx_k_move_dst && dst_acc);
  c_copy_back: cover property (o_wr_en && kind == dmx_k_copy);
  c_store: cover property (o_wr_en && kind == dmx_k_store);

endmodule : dmx_exec

// ### dmx_exec_tb.sv
// Self-checking bench of the data-move executor with a reference model.
// Assumes dmx_pkg, dmx_defs.svh and dmx_exec are compiled before it.
`include "dmx_defs.svh"
module dmx_exec_tb
  import dmx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        i_clk        = 1'b0;     // Core clock, 8 ns
  logic        i_reset      = 1'b1;     // Asynchronous reset
  logic [15:0] i_word       = 16'h0000; // Program word
  logic        i_word_valid = 1'b0;     // Word offered this Q1
  logic [7:0]  i_rd_data    = 8'h00;    // Memory read answer
  dmx_phase_t  o_phase;                 // Quarter phase
  logic        o_rd_en;                 // Read strobe
  logic [11:0] o_rd_addr;               // Read address
  logic        o_wr_en;                 // Write strobe
  logic [11:0] o_wr_addr;               // Write address
  logic [7:0]  o_wr_data;               // Write data
  logic [7:0]  o_accum;                 // Accumulator
  logic [7:0]  o_bank;                  // Bank select
  logic [15:0] o_ptr0;                  // Pointer 0
  logic [15:0] o_ptr1;                  // Pointer 1
  logic [15:0] o_ptr2;                  // Pointer 2
  logic        o_flag_n;                // Negative flag
  logic        o_flag_z;                // Zero flag

  logic [7:0]  mem [4096];              // Data memory image
  logic [7:0]  m_acc  = 8'h00;          // Model accumulator
  logic [7:0]  m_bank = 8'h00;          // Model bank select
  logic [15:0] m_ptr [3];               // Model pointers
  logic        m_n    = 1'b0;           // Model flags
  logic        m_z    = 1'b0;
  int          pend   = 0;              // 0 none, 1 pointer, 2 move
  logic [1:0]  p_idx;                   // Pending pointer index
  logic [7:0]  p_val;                   // Pending move value
  logic [19:0] exp_q [$];               // Expected writes
  logic [19:0] got_q [$];               // Seen writes
  logic [15:0] exr_q [$];               // Expected reads, {phase, addr}
  logic [15:0] gor_q [$];               // Seen reads, {phase, addr}
  int          error_cnt       = 0;
  int          samples_checked = 0;
  int          cycles          = 0;
  logic [31:0] seed = 32'hf93f;         // Random state

  dmx_exec i_dut (
    .i_clk(i_clk), .i_reset(i_reset), .i_word(i_word),
    .i_word_valid(i_word_valid), .i_rd_data(i_rd_data),
    .o_phase(o_phase), .o_rd_en(o_rd_en), .o_rd_addr(o_rd_addr),
    .o_wr_en(o_wr_en), .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data),
    .o_accum(o_accum), .o_bank(o_bank), .o_ptr0(o_ptr0),
    .o_ptr1(o_ptr1), .o_ptr2(o_ptr2), .o_flag_n(o_flag_n),
    .o_flag_z(o_flag_z));

  // Clock generator
  always #4 i_clk = ~i_clk;

  // Memory answers reads, scrambles the bus when idle outside Q3; collects writes
  always @(negedge i_clk) begin
    if (o_wr_en === 1'b1) got_q.push_back({o_wr_addr, o_wr_data});
    if (o_wr_en === 1'b1)
      chk("wr_phase", {16'h0, dmx_ph_q4}, {16'h0, o_phase});
    if (o_rd_en === 1'b1) gor_q.push_back({o_phase, o_rd_addr});
    if (o_rd_en === 1'b1) i_rd_data <= mem[o_rd_addr];
    else if (o_phase !== dmx_ph_q3) i_rd_data <= ~i_rd_data;
  end

  // Hang guard
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 6000) begin
      error_cnt++;
      conclude();
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Banked address of an 8-bit field
  function automatic logic [11:0] fadr(logic a, logic [7:0] f);
    if (a) return {m_bank[3:0], f};
    return (f < 8'h80) ? {4'h0, f} : {4'hf, f};
  endfunction : fadr

  // Accumulator sits in the data space; other sources need a Q2 read
  function automatic logic [7:0] rd(logic [11:0] ad);
    if (ad == `DMX_ACC_ADDR) return m_acc;
    exr_q.push_back({dmx_ph_q2, ad});
    return mem[ad];
  endfunction : rd

  task automatic wr(logic [11:0] ad, logic [7:0] v);
    if (ad == `DMX_ACC_ADDR) m_acc = v;
    else begin
      exp_q.push_back({ad, v});
      mem[ad] = v;
    end
  endtask : wr

  // Reference execution of one valid word
  task automatic model(logic [15:0] w);
    logic [7:0] v;
    logic [11:0] ad;
    if (pend == 1) begin
      if (w[15:8] == 8'hf0 && p_idx != 2'd3)
        m_ptr[p_idx][7:0] = w[7:0];
      pend = 0;
    end else if (pend == 2) begin
      if (w[15:12] == 4'hf) wr(w[11:0], p_val);
      pend = 0;
    end else if (w[15:10] == 6'h38) begin
      p_idx = w[9:8];
      if (p_idx != 2'd3) m_ptr[p_idx][15:8] = {4'h0, w[3:0]};
      pend = 1;
    end else if (w[15:10] == 6'h14) begin
      ad = fadr(w[8], w[7:0]);
      v = rd(ad);
      m_n = v[7];
      m_z = (v == 8'h00);
      if (w[9]) wr(ad, v);
      else m_acc = v;
    end else if (w[15:12] == 4'hc) begin
      p_val = rd(w[11:0]);
      pend = 2;
    end else if (w[15:8] == 8'h01) m_bank = {4'h0, w[3:0]};
    else if (w[15:8] == 8'h0e) m_acc = w[7:0];
    else if (w[15:9] == 7'h37) wr(fadr(w[8], w[7:0]), m_acc);
  endtask : model

  task automatic chk(string nm, logic [19:0] e, logic [19:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask : chk

  // Wait for Q1, compare the previous cycle's results, offer a word
  task automatic step(logic [15:0] w, logic vl);
    int n;
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (o_phase !== dmx_ph_q1 && n < 8);
    chk("phase", {16'h0, dmx_ph_q1}, {16'h0, o_phase});
    chk("accum", {12'h0, m_acc}, {12'h0, o_accum});
    chk("bank", {12'h0, m_bank}, {12'h0, o_bank});
    chk("ptr0", {4'h0, m_ptr[0]}, {4'h0, o_ptr0});
    chk("ptr1", {4'h0, m_ptr[1]}, {4'h0, o_ptr1});
    chk("ptr2", {4'h0, m_ptr[2]}, {4'h0, o_ptr2});
    chk("flags", {18'h0, m_n, m_z}, {18'h0, o_flag_n, o_flag_z});
    chk("writes", 20'(exp_q.size()), 20'(got_q.size()));
    while (exp_q.size() > 0 && got_q.size() > 0)
      chk("write", exp_q.pop_front(), got_q.pop_front());
    exp_q.delete();
    got_q.delete();
    chk("reads", 20'(exr_q.size()), 20'(gor_q.size()));
    while (exr_q.size() > 0 && gor_q.size() > 0)
      chk("read", {4'h0, exr_q.pop_front()}, {4'h0, gor_q.pop_front()});
    exr_q.delete();
    gor_q.delete();
    if (vl) model(w);
    i_word = w;
    i_word_valid = vl;
  endtask : step

  // One random instruction, sometimes broken or stretched
  task automatic rand_instr();
    logic [31:0] r;
    logic [1:0] ix;
    logic [11:0] s;
    r = rnd();
    ix = r[9:8];
    s = r[3] ? `DMX_ACC_ADDR : r[27:16];
    case (r[2:0])
      3'd0: begin
        step({6'h38, ix, 4'h0, r[15:12]}, 1'b1);
        if (r[7]) step(r[31:16], 1'b0);
        step({8'hf0, r[23:16]}, 1'b1);
      end
      3'd1: step({6'h14, r[9:8], r[23:16]}, 1'b1);
      3'd2: begin
        step({4'hc, s}, 1'b1);
        if (r[7]) step(r[31:16], 1'b0);
        // Destinations stay in the lower half of data space or name the accumulator
        if (r[5] & r[6]) step({8'h0e, r[15:8]}, 1'b1);
        else step({4'hf, r[4] ? `DMX_ACC_ADDR : {1'b0, r[30:20]}}, 1'b1);
      end
      3'd3: step({8'h01, r[23:16]}, 1'b1);
      3'd4: step({8'h0e, r[23:16]}, 1'b1);
      3'd5: step({7'h37, r[8], r[23:16]}, 1'b1);
      3'd6: step(r[31:16], 1'b0);
      default: step({4'hf, r[27:16]}, 1'b1);
    endcase
  endtask : rand_instr

  task automatic conclude();
    $display("Checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude

  // Main sequence: reset, directed cases, then a random stream
  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = 8'(rnd());
    mem[12'h023] = 8'h80;
    mem[12'h024] = 8'h00;
    for (int i = 0; i < 3; i++) m_ptr[i] = 16'h0000;
    repeat (12) @(negedge i_clk);
    i_reset = 1'b0;
    step({8'h0e, 8'h5a}, 1'b1);
    step({8'h01, 8'hff}, 1'b1);
    step({6'h38, 2'd2, 4'h0, 4'h3}, 1'b1);
    step({8'hf0, 8'hab}, 1'b1);
    step({4'hc, `DMX_ACC_ADDR}, 1'b1);
    step({4'hf, 12'h123}, 1'b1);
    step({6'h14, 2'b00, 8'h23}, 1'b1);
    step({6'h14, 2'b10, 8'h24}, 1'b1);
    step({7'h37, 1'b1, 8'h45}, 1'b1);
    step({4'hc, 12'h7ff}, 1'b1);
    step({4'hf, `DMX_ACC_ADDR}, 1'b1);
    step({4'hf, 12'h456}, 1'b1);
    repeat (400) rand_instr();
    step(16'h0000, 1'b0);
    step(16'h0000, 1'b0);
    conclude();
  end

endmodule : dmx_exec_tb
